//--- dcwb_map.svh
// Register offsets, field positions and reset values of the write burst block
`ifndef DCWB_MAP_SVH
`define DCWB_MAP_SVH

`define DCWB_OFF_CCR     8'h00
`define DCWB_OFF_DADDR   8'h04
`define DCWB_OFF_CMD     8'h08
`define DCWB_OFF_SEC     8'h0C
`define DCWB_OFF_STATUS  8'h10
`define DCWB_OFF_MASK    8'h14
`define DCWB_OFF_STATE   8'h18

`define DCWB_CCR_DPROT   24:22
`define DCWB_CCR_NSBIT   23
`define DCWB_CCR_DLEN    21:18
`define DCWB_CCR_DSIZE   17:15
`define DCWB_CCR_DINC    14
`define DCWB_CCR_SC2     13
`define DCWB_CCR_SC1     12
`define DCWB_CCR_SC0     11

`define DCWB_CMD_START   0
`define DCWB_CMD_CLRABT  1
`define DCWB_SEC_BIT     0
`define DCWB_STS_DONE    0
`define DCWB_STS_ABORT   1

`define DCWB_RST_WORD    32'h0000_0000
`define DCWB_RST_SEC     1'b0
`define DCWB_RST_STS     2'h0
`define DCWB_ONE_BEAT    9'h001

`endif

//--- dcwb_pkg.sv
// Types shared by the write burst block
package dcwb_pkg;

    typedef enum logic [2:0] {
        DCWB_IDLE  = 3'b001,
        DCWB_ADDR  = 3'b010,
        DCWB_ABORT = 3'b100
    } dcwb_state_t;

    // One write address request
    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
        logic [3:0]  len;
        logic [2:0]  size;
        logic [1:0]  burst;
        logic [2:0]  prot;
    } dcwb_aw_t;

    typedef struct packed {
        logic [31:0] ccr;
        logic [31:0] daddr;
        logic        sec;
        logic [1:0]  sts;
        logic [1:0]  msk;
        dcwb_state_t st;
        logic [31:0] rdata;
        logic [8:0]  store_bytes;
        dcwb_aw_t    aw;
    } dcwb_regs_t;

endpackage

//--- dcwb_channel.sv
// One channel's destination write burst attributes and write address issue
//
// Notes on behaviour
// - Only a channel in the secure state may issue a write with the secure protection bit one low.
// - A non-secure channel whose destination protection bit one is low aborts instead of writing.
// - The destination burst length field gives beats per burst as its value plus one.
// - Each store moves beats times bytes per beat out of the shared data queue.
// - The write burst length is driven straight from the destination burst length field.
// - The destination beat size field codes 1 to 16 bytes per beat; codes above four are reserved.
// - The write transfer size is driven straight from the destination beat size field.
// - The destination increment bit picks fixed or incrementing bursts on burst type bit zero.
// - The source cache field bits drive the read cache attributes, bit 13 to bit 2 and bit 12 to bit 1.
// - The destination protection field drives the three write protection signals bit for bit.
//
// The implementer's own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "dcwb_map.svh"

module dcwb_channel
    import dcwb_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RST_N,
    input  wire logic [7:0]  ADDR,
    input  wire logic [31:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [31:0] RDATA,
    output dcwb_aw_t         AW,
    input  wire logic        AWREADY,
    output logic      [3:0]  ARCACHE,
    output logic      [8:0]  STORE_BYTES,
    output logic             STORE_GO,
    output logic             IRQ
);

    // *****************************************************************
    // State
    // *****************************************************************
    dcwb_regs_t r_ff;
    dcwb_regs_t nxt_r;

    logic       start;
    logic       clr_abt;
    logic       ns_secure_req;
    logic [1:0] ev;
    logic [8:0] beats;

    // *****************************************************************
    // Next state
    // *****************************************************************
    always_comb begin
        nxt_r   = r_ff;
        ev      = 2'h0;
        start   = WR && (ADDR == `DCWB_OFF_CMD) && WDATA[`DCWB_CMD_START];
        clr_abt = WR && (ADDR == `DCWB_OFF_CMD) && WDATA[`DCWB_CMD_CLRABT];
        ns_secure_req = !r_ff.sec && !r_ff.ccr[`DCWB_CCR_NSBIT];
        beats   = {5'h00, r_ff.ccr[`DCWB_CCR_DLEN]} + `DCWB_ONE_BEAT;

        // Configuration other than the mask is frozen while a burst is being offered
        if (WR && (r_ff.st != DCWB_ADDR)) begin
            case (ADDR)
                `DCWB_OFF_CCR:   nxt_r.ccr = WDATA;
                `DCWB_OFF_DADDR: nxt_r.daddr = WDATA;
                `DCWB_OFF_SEC:   nxt_r.sec = WDATA[`DCWB_SEC_BIT];
                default: ;
            endcase
        end
        if (WR && (ADDR == `DCWB_OFF_MASK)) begin
            nxt_r.msk = WDATA[1:0];
        end

        case (r_ff.st)
            DCWB_IDLE: begin
                if (start) begin
                    if (ns_secure_req) begin
                        nxt_r.st = DCWB_ABORT;
                        ev[`DCWB_STS_ABORT] = 1'b1;
                    end else begin
                        nxt_r.st          = DCWB_ADDR;
                        nxt_r.aw.valid    = 1'b1;
                        nxt_r.aw.addr     = r_ff.daddr;
                        nxt_r.aw.len      = r_ff.ccr[`DCWB_CCR_DLEN];
                        nxt_r.aw.size     = r_ff.ccr[`DCWB_CCR_DSIZE];
                        nxt_r.aw.burst    = {1'b0, r_ff.ccr[`DCWB_CCR_DINC]};
                        nxt_r.aw.prot     = r_ff.ccr[`DCWB_CCR_DPROT];
                        // Reserved size codes give the same shifted count, wrapped to 9 bits
                        nxt_r.store_bytes = 9'(beats << r_ff.ccr[`DCWB_CCR_DSIZE]);
                    end
                end
            end
            DCWB_ADDR: begin
                if (AWREADY) begin
                    nxt_r.st       = DCWB_IDLE;
                    nxt_r.aw.valid = 1'b0;
                    ev[`DCWB_STS_DONE] = 1'b1;
                end
            end
            DCWB_ABORT: begin
                // Held until software acknowledges the fault
                if (clr_abt) begin
                    nxt_r.st = DCWB_IDLE;
                end
            end
            default: begin
                nxt_r.st       = DCWB_IDLE;
                nxt_r.aw.valid = 1'b0;
            end
        endcase

        // Sticky events: a set in the clearing cycle wins
        if (WR && (ADDR == `DCWB_OFF_STATUS)) begin
            nxt_r.sts = r_ff.sts & ~WDATA[1:0];
        end
        nxt_r.sts = nxt_r.sts | ev;

        nxt_r.rdata = `DCWB_RST_WORD;
        if (RD) begin
            case (ADDR)
                `DCWB_OFF_CCR:    nxt_r.rdata = r_ff.ccr;
                `DCWB_OFF_DADDR:  nxt_r.rdata = r_ff.daddr;
                `DCWB_OFF_SEC:    nxt_r.rdata = {31'h0000_0000, r_ff.sec};
                `DCWB_OFF_STATUS: nxt_r.rdata = {30'h0000_0000, r_ff.sts};
                `DCWB_OFF_MASK:   nxt_r.rdata = {30'h0000_0000, r_ff.msk};
                `DCWB_OFF_STATE:  nxt_r.rdata = {20'h0_0000, r_ff.store_bytes, r_ff.st};
                default:          nxt_r.rdata = `DCWB_RST_WORD;
            endcase
        end
    end

    // *****************************************************************
    // Registers
    // *****************************************************************
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            r_ff.ccr         <= `DCWB_RST_WORD;
            r_ff.daddr       <= `DCWB_RST_WORD;
            r_ff.sec         <= `DCWB_RST_SEC;
            r_ff.sts         <= `DCWB_RST_STS;
            r_ff.msk         <= `DCWB_RST_STS;
            r_ff.st          <= DCWB_IDLE;
            r_ff.rdata       <= `DCWB_RST_WORD;
            r_ff.store_bytes <= 9'h000;
            r_ff.aw          <= '0;
        end else begin
            r_ff <= nxt_r;
        end
    end

    // *****************************************************************
    // Outputs
    // *****************************************************************
    assign RDATA       = r_ff.rdata;
    assign AW          = r_ff.aw;
    assign STORE_BYTES = r_ff.store_bytes;
    assign STORE_GO    = r_ff.aw.valid && AWREADY;
    // Bit 3 tied low; software keeps bits 2:1 off the illegal pair
    assign ARCACHE     = {1'b0, r_ff.ccr[`DCWB_CCR_SC2], r_ff.ccr[`DCWB_CCR_SC1], r_ff.ccr[`DCWB_CCR_SC0]};
    assign IRQ         = |(r_ff.sts & r_ff.msk);

endmodule

//--- dcwb_slave.sv
// Write address acceptor with a chosen stall
`timescale 1ns/1ps
module dcwb_slave
    import dcwb_pkg::*;
(
    input wire logic       CLK,
    input wire logic       RST_N,
    input dcwb_aw_t        AW,
    input wire logic [3:0] STALL,
    output logic           AWREADY
);
    logic [3:0] wait_ff;
    always_ff @(posedge CLK) begin
        if (!RST_N || !AW.valid || AWREADY) wait_ff <= 4'h0;
        else wait_ff <= wait_ff + 4'h1;
    end
    // Ready only while offered, so a stale ready never leaks
    assign AWREADY = AW.valid && (wait_ff == STALL);
endmodule

//--- dcwb_channel_assertions.sv
// Port checker of the write burst block
`timescale 1ns/1ps
module dcwb_channel_assertions
    import dcwb_pkg::*;
(
    input wire logic        CLK,
    input wire logic        RST_N,
    input wire logic [7:0]  ADDR,
    input wire logic [31:0] WDATA,
    input wire logic        WR,
    input wire logic        RD,
    input wire logic [31:0] RDATA,
    input dcwb_aw_t         AW,
    input wire logic        AWREADY,
    input wire logic [3:0]  ARCACHE,
    input wire logic [8:0]  STORE_BYTES,
    input wire logic        STORE_GO,
    input wire logic        IRQ
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    AST_GO: assert property (STORE_GO == (AW.valid && AWREADY)) else $error("go");
    AST_HOLD: assert property (AW.valid && !AWREADY |=> AW.valid && $stable(AW)) else $error("hold");
    AST_BURST: assert property (AW.valid |-> AW.burst[1] == 1'b0) else $error("burst");
    AST_BYTES: assert property (AW.valid && AW.size <= 3'h4
        |-> STORE_BYTES == ({5'h0, AW.len} + 9'h1) << AW.size) else $error("bytes");
    AST_CACHE: assert property (ARCACHE[3] == 1'b0) else $error("cache");
    AST_RDATA: assert property (!$past(RD) |-> RDATA == 32'h0) else $error("rdata");
    AST_ONE: assert property (AW.valid && AWREADY |=> !AW.valid) else $error("one");
    AST_START: assert property ($rose(AW.valid)
        |-> $past(WR) && $past(ADDR) == 8'h08 && $past(WDATA[0])) else $error("start");
endmodule
bind dcwb_channel dcwb_channel_assertions chk_u(.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .AW(AW), .AWREADY(AWREADY), .ARCACHE(ARCACHE),
    .STORE_BYTES(STORE_BYTES), .STORE_GO(STORE_GO), .IRQ(IRQ));

//--- dcwb_channel_tb.sv
// Testbench of the write burst block
`timescale 1ns/1ps
module dcwb_channel_tb
    import dcwb_pkg::*;
;
    logic        clk = 0, rst_n = 0, wr = 0, rd = 0, awr, go, irq;
    logic [7:0]  adr = 0;
    logic [31:0] wd = 0, rdv, ccr, rdata;
    logic [3:0]  stall = 0, arc;
    logic [8:0]  sb, sbc;
    dcwb_aw_t    aw, cap;
    int          bad_count = 0, n_compared = 0, cyc = 0;
    always #5 clk = ~clk;
    dcwb_channel dut_u(.CLK(clk), .RST_N(rst_n), .ADDR(adr), .WDATA(wd), .WR(wr), .RD(rd),
        .RDATA(rdata), .AW(aw), .AWREADY(awr), .ARCACHE(arc), .STORE_BYTES(sb), .STORE_GO(go), .IRQ(irq));
    dcwb_slave slv_u(.CLK(clk), .RST_N(rst_n), .AW(aw), .STALL(stall), .AWREADY(awr));
    task end_sim;
        $display("Compared %0d, bad %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            bad_count++;
            end_sim();
        end
    end
    task chk(string n, logic [31:0] e, logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task wrt(logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        adr <= a;
        wd <= d;
        wr <= 1;
        @(posedge clk);
        wr <= 0;
        #1;
    endtask
    task rdt(logic [7:0] a);
        @(posedge clk);
        adr <= a;
        rd <= 1;
        @(posedge clk);
        rd <= 0;
        #1 rdv = rdata;
    endtask
    // Wait bounded for the address handshake
    task burst;
        wrt(8'h08, 32'h1);
        for (int k = 0; k < 20 && go !== 1'b1; k++) begin
            @(posedge clk);
            #1;
        end
        chk("go", 1, go);
        cap = aw;
        sbc = sb;
        @(posedge clk);
        #1;
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1;
        rdt(8'h18);
        chk("state", 32'h1, rdv);
        wrt(8'h14, 32'h3);
        // Cache bit 13 stays low so ARCACHE[2:1] is never 10
        for (int i = 0; i < 10; i++) begin
            // Secure passes clear protection bit one, non-secure passes keep it set
            ccr = {7'h0, (i[1] ? {i[2], 1'b0, i[0]} : (i[2:0] | 3'h2)), i > 4 ? 4'hF : 4'h0, 3'(i % 5), i[0], 1'b0,
                   i[1:0], 11'h0};
            stall <= 4'(i % 3);
            wrt(8'h0C, {31'h0, i[1]});
            wrt(8'h00, ccr);
            wrt(8'h04, 32'h8000_0000 | (32'(i) << 4));
            burst();
            chk("addr", 32'h8000_0000 | (32'(i) << 4), cap.addr);
            chk("len", ccr[21:18], cap.len);
            chk("size", ccr[17:15], cap.size);
            chk("burst", {1'b0, ccr[14]}, cap.burst);
            chk("prot", ccr[24:22], cap.prot);
            chk("bytes", ({5'h0, ccr[21:18]} + 9'h1) << ccr[17:15], sbc);
            chk("cache", {1'b0, ccr[13:11]}, arc);
            chk("irq", 1, irq);
            wrt(8'h10, 32'h1);
            chk("irq", 0, irq);
        end
        wrt(8'h0C, 32'h0);
        wrt(8'h00, 32'h0);
        wrt(8'h08, 32'h1);
        rdt(8'h18);
        chk("abort", 32'h4, rdv[2:0]);
        chk("awv", 0, aw.valid);
        rdt(8'h10);
        chk("sts", 32'h2, rdv);
        wrt(8'h08, 32'h2);
        wrt(8'h10, 32'h2);
        chk("irq", 0, irq);
        rdt(8'h18);
        chk("idle", 32'h1, rdv[2:0]);
        rdt(8'hFC);
        chk("unmap", 32'h0, rdv);
        end_sim();
    end
endmodule
